// ==== rtl/pps_regs.svh ====
// Constants for the PCI port control signalling block
`ifndef PPS_REGS_SVH
`define PPS_REGS_SVH
`define PPS_DEVSEL_WAIT 5
`define PPS_SYNC_LAT 2
`define PPS_CNT_W 3
`define PPS_CMD_CFG_READ 4'hA
`define PPS_CMD_CFG_WRITE 4'hB
`endif

// ==== rtl/pps_pkg.sv ====
// Types for the PCI port control signalling block
package pps_pkg;
	typedef enum logic [4:0] {
		MS_IDLE = 5'h01,
		MS_WAIT = 5'h02,
		MS_DATA = 5'h04,
		MS_TURN = 5'h08,
		MS_ABORT = 5'h10
	} pps_mst_t;
	typedef enum logic [3:0] {
		TS_IDLE = 4'h1,
		TS_CLAIM = 4'h2,
		TS_DATA = 4'h4,
		TS_TURN = 4'h8
	} pps_tgt_t;
	typedef struct packed {
		logic o;
		logic oe;
	} pps_drv_t;
	typedef struct packed {
		logic frame;
		logic irdy;
		logic trdy;
		logic devsel;
		logic stop;
		logic lock;
		logic idsel;
		logic par;
		logic serr;
	} pps_pins_t;
endpackage

// ==== rtl/pps_ctrl.sv ====
// PCI port control signal engine: master handshake, target claim, parity and errors
// ----------------------------------------------------------------------------
// Overview of operation
// - Initiator ready held until data phase ends
// - Target ready held until data phase ends
// - Claiming target asserts device select
// - No device select in five cycles: abort
// - Initiator ends transaction on target stop
// - Drive deasserted one cycle before release
// - Upstream lock requests are not propagated
// - Config type 0 claimed only with idsel
// - Parity error flagged on bad received data
// - System error open drain, never high
// - System error on address parity fault
// - Frame marks access; deasserts at last
// - Word moves when both readies asserted
// - Even parity over address data and command
// ----------------------------------------------------------------------------
`include "pps_regs.svh"
module pps_ctrl (
	input wire logic mclk,
	input wire logic nrst,
	input wire pps_pkg::pps_pins_t pin_i,
	input wire logic [31:0] ad_i,
	input wire logic [3:0] cbe_i,
	input wire logic mst_start,
	input wire logic mst_last,
	input wire logic tgt_ready,
	input wire logic tgt_stop_req,
	input wire logic serr_enable,
	input wire logic perr_enable,
	output logic frame_o,
	output logic frame_oe,
	output logic irdy_o,
	output logic irdy_oe,
	output logic trdy_o,
	output logic trdy_oe,
	output logic devsel_o,
	output logic devsel_oe,
	output logic stop_o,
	output logic stop_oe,
	output logic perr_o,
	output logic perr_oe,
	output logic serr_o,
	output logic serr_oe,
	output logic mst_abort,
	output logic mst_xfer,
	output logic tgt_xfer,
	output logic cfg_hit,
	output logic lock_seen
);
	import pps_pkg::*;

	function automatic logic even_par(input logic [31:0] a, input logic [3:0] c);
		even_par = ^{a, c};
	endfunction

	// ------------------------------------------------------------------------
	// Input synchronisers
	// ------------------------------------------------------------------------
	pps_pins_t p1_q, ps_q, pd_q;
	logic [31:0] ad1_q, ad_q, adp_q;
	logic [3:0] cbe1_q, cbe_q, cbep_q;
	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
		begin
			p1_q <= '1;
			ps_q <= '1;
			pd_q <= '1;
			ad1_q <= '0;
			ad_q <= '0;
			adp_q <= '0;
			cbe1_q <= '0;
			cbe_q <= '0;
			cbep_q <= '0;
		end
		else
		begin
			p1_q <= pin_i;
			ps_q <= p1_q;
			pd_q <= ps_q;
			ad1_q <= ad_i;
			ad_q <= ad1_q;
			adp_q <= ad_q;
			cbe1_q <= cbe_i;
			cbe_q <= cbe1_q;
			cbep_q <= cbe_q;
		end
	end
	logic addr_ph;
	assign addr_ph = !ps_q.frame && pd_q.frame && pd_q.irdy;
	logic data_xfer;
	assign data_xfer = !ps_q.irdy && !ps_q.trdy;

	// ------------------------------------------------------------------------
	// Master side
	// ------------------------------------------------------------------------
	pps_mst_t ms_q;
	logic [`PPS_CNT_W-1:0] wait_q;
	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
		begin
			ms_q <= MS_IDLE;
			wait_q <= '0;
			frame_o <= 1'b1;
			frame_oe <= 1'b0;
			irdy_o <= 1'b1;
			irdy_oe <= 1'b0;
			mst_abort <= 1'b0;
			mst_xfer <= 1'b0;
		end
		else
		begin
			mst_abort <= 1'b0;
			mst_xfer <= 1'b0;
			case (ms_q)
				MS_IDLE:
				begin
					frame_oe <= 1'b0;
					irdy_oe <= 1'b0;
					if (mst_start && ps_q.frame && ps_q.irdy)
					begin
						frame_o <= 1'b0;
						frame_oe <= 1'b1;
						irdy_o <= 1'b0;
						irdy_oe <= 1'b1;
						wait_q <= '0;
						ms_q <= MS_WAIT;
					end
				end
				MS_WAIT:
				begin
					if (!ps_q.devsel)
						ms_q <= MS_DATA;
					else if (wait_q == `PPS_CNT_W'(`PPS_DEVSEL_WAIT + `PPS_SYNC_LAT - 1))
					begin
						frame_o <= 1'b1;
						mst_abort <= 1'b1;
						ms_q <= MS_ABORT;
					end
					else
						wait_q <= wait_q + 1'b1;
				end
				MS_DATA:
				begin
					if (mst_last || !ps_q.stop)
						frame_o <= 1'b1;
					if (data_xfer)
						mst_xfer <= 1'b1;
					if ((data_xfer && frame_o) || (!ps_q.stop && frame_o))
					begin
						irdy_o <= 1'b1;
						ms_q <= MS_TURN;
					end
				end
				MS_ABORT:
				begin
					irdy_o <= 1'b1;
					ms_q <= MS_TURN;
				end
				MS_TURN:
				begin
					frame_oe <= 1'b0;
					irdy_oe <= 1'b0;
					ms_q <= MS_IDLE;
				end
				default: ms_q <= MS_IDLE;
			endcase
		end
	end

	// ------------------------------------------------------------------------
	// Target side
	// ------------------------------------------------------------------------
	pps_tgt_t ts_q;
	logic cfg_cmd;
	assign cfg_cmd = (cbe_q == `PPS_CMD_CFG_READ) || (cbe_q == `PPS_CMD_CFG_WRITE);
	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
		begin
			ts_q <= TS_IDLE;
			trdy_o <= 1'b1;
			trdy_oe <= 1'b0;
			devsel_o <= 1'b1;
			devsel_oe <= 1'b0;
			stop_o <= 1'b1;
			stop_oe <= 1'b0;
			cfg_hit <= 1'b0;
			tgt_xfer <= 1'b0;
			lock_seen <= 1'b0;
		end
		else
		begin
			tgt_xfer <= 1'b0;
			lock_seen <= addr_ph && !ps_q.lock;
			case (ts_q)
				TS_IDLE:
				begin
					trdy_oe <= 1'b0;
					devsel_oe <= 1'b0;
					stop_oe <= 1'b0;
					cfg_hit <= 1'b0;
					if (addr_ph && cfg_cmd && ps_q.idsel && (ad_q[1:0] == 2'b00))
					begin
						cfg_hit <= 1'b1;
						devsel_o <= 1'b0;
						devsel_oe <= 1'b1;
						trdy_oe <= 1'b1;
						stop_oe <= 1'b1;
						ts_q <= TS_CLAIM;
					end
				end
				TS_CLAIM, TS_DATA:
				begin
					if (tgt_stop_req)
						stop_o <= 1'b0;
					if (tgt_ready || !trdy_o)
						trdy_o <= 1'b0;
					if ((!trdy_o && !ps_q.irdy) || (!stop_o && ps_q.frame))
					begin
						tgt_xfer <= !trdy_o && !ps_q.irdy;
						if (ps_q.frame)
						begin
							trdy_o <= 1'b1;
							devsel_o <= 1'b1;
							stop_o <= 1'b1;
							ts_q <= TS_TURN;
						end
						else if (!stop_o)
							trdy_o <= 1'b1;
						else
							trdy_o <= !tgt_ready;
					end
					else
						ts_q <= TS_DATA;
				end
				TS_TURN:
				begin
					trdy_oe <= 1'b0;
					devsel_oe <= 1'b0;
					stop_oe <= 1'b0;
					cfg_hit <= 1'b0;
					ts_q <= TS_IDLE;
				end
				default: ts_q <= TS_IDLE;
			endcase
		end
	end

	// ------------------------------------------------------------------------
	// Parity and system error
	// ------------------------------------------------------------------------
	logic addr_chk_q, data_chk_q;
	logic [1:0] tact_q;
	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
		begin
			addr_chk_q <= 1'b0;
			data_chk_q <= 1'b0;
			tact_q <= 2'b00;
			perr_o <= 1'b1;
			perr_oe <= 1'b0;
			serr_o <= 1'b0;
			serr_oe <= 1'b0;
		end
		else
		begin
			addr_chk_q <= addr_ph;
			// Target state delayed to line up with the synced readies
			tact_q <= {tact_q[0], (ts_q == TS_DATA || ts_q == TS_CLAIM)};
			data_chk_q <= data_xfer && tact_q[1];
			if (perr_enable && data_chk_q && (even_par(adp_q, cbep_q) != ps_q.par))
			begin
				perr_o <= 1'b0;
				perr_oe <= 1'b1;
			end
			else if (!perr_o)
				perr_o <= 1'b1;
			else
				perr_oe <= 1'b0;
			serr_o <= 1'b0;
			serr_oe <= serr_enable && addr_chk_q && (even_par(adp_q, cbep_q) != ps_q.par);
		end
	end

	// ------------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------------
	property p_abort_time;
		@(posedge mclk) disable iff (!nrst)
		$rose(ms_q == MS_WAIT) ##0 (ps_q.devsel [*7]) |-> ##[0:1] mst_abort;
	endproperty
	a_abort_time: assert property (p_abort_time) else $error("no abort after devsel wait");
	property p_irdy_hold;
		@(posedge mclk) disable iff (!nrst)
		(ms_q == MS_DATA && !irdy_o && !data_xfer && ps_q.stop) |=> !irdy_o;
	endproperty
	a_irdy_hold: assert property (p_irdy_hold) else $error("irdy released early");
	property p_trdy_hold;
		@(posedge mclk) disable iff (!nrst)
		(trdy_oe && !trdy_o && ps_q.irdy && !ps_q.frame) |=> !trdy_o;
	endproperty
	a_trdy_hold: assert property (p_trdy_hold) else $error("trdy released early");
	property p_turn_irdy;
		@(posedge mclk) disable iff (!nrst)
		$fell(irdy_oe) |-> $past(irdy_o);
	endproperty
	a_turn_irdy: assert property (p_turn_irdy) else $error("irdy floated while asserted");
	property p_turn_devsel;
		@(posedge mclk) disable iff (!nrst)
		$fell(devsel_oe) |-> $past(devsel_o) && $past(trdy_o) && $past(stop_o);
	endproperty
	a_turn_devsel: assert property (p_turn_devsel) else $error("target line floated asserted");
	property p_serr_low;
		@(posedge mclk) disable iff (!nrst)
		serr_oe |-> !serr_o;
	endproperty
	a_serr_low: assert property (p_serr_low) else $error("serr driven high");
	property p_claim_idsel;
		@(posedge mclk) disable iff (!nrst)
		$rose(cfg_hit) |-> $past(ps_q.idsel) && !devsel_o;
	endproperty
	a_claim_idsel: assert property (p_claim_idsel) else $error("claim without idsel");
	property p_stop_honour;
		@(posedge mclk) disable iff (!nrst)
		(ms_q == MS_DATA && !ps_q.stop) |=> frame_o;
	endproperty
	a_stop_honour: assert property (p_stop_honour) else $error("stop ignored");
	property p_serr_cause;
		@(posedge mclk) disable iff (!nrst)
		serr_oe |-> $past(serr_enable) && $past(addr_chk_q);
	endproperty
	a_serr_cause: assert property (p_serr_cause) else $error("serr without cause");
	property p_xfer_both;
		@(posedge mclk) disable iff (!nrst)
		mst_xfer |-> $past(!ps_q.irdy && !ps_q.trdy);
	endproperty
	a_xfer_both: assert property (p_xfer_both) else $error("transfer without both readies");
	c_abort: cover property (@(posedge mclk) disable iff (!nrst) mst_abort);
	c_mxfer: cover property (@(posedge mclk) disable iff (!nrst) mst_xfer);
	c_cfg: cover property (@(posedge mclk) disable iff (!nrst) tgt_xfer && cfg_hit);
	c_perr: cover property (@(posedge mclk) disable iff (!nrst) $fell(perr_o));
endmodule // pps_ctrl

// ==== verification/pps_far_model.sv ====
// Far side target model that answers the engine's master cycles
module pps_far_model (
	input wire logic mclk,
	input wire logic nrst,
	input wire logic frame,
	input wire logic irdy,
	input wire logic act,
	input wire logic [1:0] lat,
	input wire logic stp,
	output logic devsel,
	output logic trdy,
	output logic stop
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [1:0] st_q;
	logic [1:0] cnt_q;
	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
		begin
			st_q <= 2'h0;
			cnt_q <= 2'h0;
			devsel <= 1'b1;
			trdy <= 1'b1;
			stop <= 1'b1;
		end
		else
		case (st_q)
			2'h0: if (act && !frame)
			begin
				cnt_q <= lat;
				st_q <= 2'h1;
			end
			2'h1: if (cnt_q == 2'h0)
			begin
				devsel <= 1'b0;
				trdy <= 1'b0;
				stop <= ~stp;
				st_q <= 2'h2;
			end
			else
				cnt_q <= cnt_q - 2'h1;
			2'h2: if (frame && irdy)
			begin
				devsel <= 1'b1;
				trdy <= 1'b1;
				stop <= 1'b1;
				st_q <= 2'h3;
			end
			default: st_q <= 2'h0;
		endcase
	end
endmodule // pps_far_model

// ==== verification/pci_port_control_signalling_tb_top.sv ====
// Bench for the PCI port control signal engine
`include "pps_regs.svh"
module pci_port_control_signalling_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	import pps_pkg::*;
	logic mclk = 0, nrst = 0, m_go = 0, t_frame = 1, t_irdy = 1, t_sel = 0;
	logic bad = 0, par_q = 0, act = 0, mark = 0, t_lock = 1, stp = 0;
	logic [31:0] ad = 0, rnd = 32'h3688E49B;
	logic [3:0] cbe = 0;
	logic [1:0] lat = 0;
	logic fo, foe, io, ioe, to, toe, dvo, dvoe, so, soe, po, poe, eo, eoe;
	logic ma, mx, tx, ch, fd, ft, fs, ls;
	logic [6:0] acc = 0;
	logic [6:0] q[$];
	pps_pins_t pin;
	int failures = 0, checks = 0, cyc = 0;
	function logic rs(input logic o, input logic oe);
		return oe ? o : 1'b1;
	endfunction
	function logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	assign pin = {rs(fo, foe) & t_frame, rs(io, ioe) & t_irdy, rs(to, toe) & ft,
		rs(dvo, dvoe) & fd, rs(so, soe) & fs, t_lock, t_sel, par_q, rs(eo, eoe)};
	pps_ctrl DUT (.mclk(mclk), .nrst(nrst), .pin_i(pin), .ad_i(ad), .cbe_i(cbe),
		.mst_start(m_go), .mst_last(1'b1), .tgt_ready(1'b1), .tgt_stop_req(1'b0),
		.serr_enable(1'b1), .perr_enable(1'b1), .frame_o(fo), .frame_oe(foe),
		.irdy_o(io), .irdy_oe(ioe), .trdy_o(to), .trdy_oe(toe), .devsel_o(dvo),
		.devsel_oe(dvoe), .stop_o(so), .stop_oe(soe), .perr_o(po), .perr_oe(poe),
		.serr_o(eo), .serr_oe(eoe), .mst_abort(ma), .mst_xfer(mx), .tgt_xfer(tx),
		.cfg_hit(ch), .lock_seen(ls));
	pps_far_model FAR (.mclk(mclk), .nrst(nrst), .frame(pin.frame), .irdy(pin.irdy),
		.act(act), .lat(lat), .stp(stp), .devsel(fd), .trdy(ft), .stop(fs));
	initial forever #50 mclk = ~mclk;
	always @(posedge mclk) par_q <= ^{ad, cbe} ^ bad;
	// ------------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------------
	task tick(input int n);
		repeat (n) @(posedge mclk);
	endtask
	task check(input string nm, input logic [6:0] e, input logic [6:0] s);
		checks++;
		if (s !== e)
		begin
			failures++;
			$display("ERROR %s expected %h seen %h", nm, e, s);
		end
	endtask
	task report_and_stop;
		if (failures == 0 && checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task close_txn;
		tick(4);
		mark <= 1;
		tick(1);
		mark <= 0;
	endtask
	task master(input logic resp, input logic [6:0] e);
		q.push_back(e);
		rnd = lfsr(rnd);
		act <= resp;
		lat <= {1'b0, rnd[0]};
		stp <= rnd[1];
		m_go <= 1;
		for (int i = 0; i < 20 && !foe; i++) tick(1);
		m_go <= 0;
		for (int i = 0; i < 40 && (ioe || foe); i++) tick(1);
		act <= 0;
		close_txn();
	endtask
	task target(input logic [3:0] cmd, input logic sel, input logic [1:0] b, input logic lk,
		input logic [6:0] e);
		q.push_back(e);
		rnd = lfsr(rnd);
		t_frame <= 0;
		cbe <= cmd;
		ad <= {rnd[31:2], 2'b00};
		t_sel <= sel;
		t_lock <= !lk;
		bad <= b[1];
		tick(1);
		rnd = lfsr(rnd);
		t_frame <= 1;
		t_irdy <= 0;
		t_lock <= 1;
		cbe <= 4'h0;
		ad <= rnd;
		bad <= b[0];
		tick(1);
		for (int i = 0; i < 20 && pin.trdy; i++) tick(1);
		t_irdy <= 1;
		t_sel <= 0;
		bad <= 0;
		for (int i = 0; i < 20 && (toe || dvoe); i++) tick(1);
		close_txn();
	endtask
	// ------------------------------------------------------------------
	// Watcher and sequence
	// ------------------------------------------------------------------
	always @(negedge mclk)
	begin
		acc = acc | {eoe & ~eo, ls, poe & ~po, ma, mx, tx, ch};
		if (mark)
		begin
			check("event set", (q.size() > 0) ? q.pop_front() : 7'h7F, acc);
			acc = 0;
		end
	end
	always @(posedge mclk)
	begin
		cyc++;
		if (cyc == 2000)
		begin
			failures++;
			report_and_stop();
		end
	end
	initial
	begin
		tick(12);
		nrst <= 1;
		tick(2);
		master(1, 7'h04);
		master(0, 7'h08);
		target(`PPS_CMD_CFG_READ, 1, 2'b00, 0, 7'h03);
		target(`PPS_CMD_CFG_WRITE, 1, 2'b01, 0, 7'h13);
		target(`PPS_CMD_CFG_WRITE, 0, 2'b10, 1, 7'h60);
		repeat (3) master(1, 7'h04);
		check("pending notes", 7'h00, 7'(q.size()));
		report_and_stop();
	end
endmodule // pci_port_control_signalling_tb_top
